//--- verilog/adc_start_ctrl.sv
// Purpose: Drives the start strobe of a 14-bit subranging converter and
//          latches its result after each falling edge.
// Assumes: Converter outputs are synchronous to sys_clk.
// Notes:   One conversion per request, or back to back while run is high.
//          sh_mode and sh_low_cycles are taken at each rising strobe edge.
//          A request that arrives mid-conversion is not queued; hold it
//          until the next rise of adc_start.
// How it works
// R1: A rising strobe edge starts the coarse pass and voids the old result.
// R2: The new result is valid no later than 50 ns after the falling edge.
// R3: Each conversion cycle lasts at least 2.0 us, longer is fine.
// R4: Continuous mode is only a repeated strobe, no faster than 500 kHz.
// R5: Without a sample-and-hold the strobe is high 1.8 us then low 0.2 us.
// R6: With a sample-and-hold it is high 2.0 us then low for the settle time.
// R7: The result is 14-bit straight binary with bit 1 as the MSB.
// R8: Overrange acts as a fifteenth bit above the 14 data bits.
// R9: The device merges coarse and fine passes into the 14-bit word.
// R10: A latch strobed by the start edge needs it delayed by over 50 ns.
// R11: Phases come from cycle counters and capture waits past 50 ns.
`timescale 1ns/1ns
`default_nettype none
module adc_start_ctrl #(
    parameter int unsigned DATA_BITS = adc_ctrl_pkg::DATA_BITS
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire logic                 start_req,
    input  wire logic                 run,
    input  wire logic                 sh_mode,
    input  wire logic [15:0]          sh_low_cycles,
    input  wire logic [DATA_BITS-1:0] adc_data,
    input  wire logic                 adc_overrange,
    output logic                      adc_start,
    output logic                      busy,
    output logic                      sample_valid,
    output logic [DATA_BITS-1:0]      sample_code,
    output logic                      sample_overrange
);
    localparam int unsigned W  = adc_ctrl_pkg::CNT_W;
    localparam int unsigned PW = adc_ctrl_pkg::DATA_BITS;

    adc_ctrl_pkg::phase_e state;
    adc_ctrl_pkg::phase_e next_state;
    logic                 timer_load;
    logic [W-1:0]         timer_value;
    logic                 timer_done;
    logic                 capture_pending;
    logic [W-1:0]         capture_count;
    logic [W-1:0]         low_len;
    logic [W-1:0]         high_len;
    logic                 go;
    logic                 enter_high;
    logic                 enter_low;
    logic                 capture_now;
    logic                 hold_mode;
    logic [W-1:0]         hold_settle;
    logic [W-1:0]         since_rise;
    logic                 rate_ok;
    adc_ctrl_pkg::sample_s fresh;
    adc_ctrl_pkg::sample_s held;

    // One decoder serves both phases, so a conversion can never mix the
    // high time of one timing set with the low time of the other.
    function automatic logic [W-1:0] phase_cycles(
        input logic         high_phase,
        input logic         hold,
        input logic [W-1:0] settle
    );
        logic [W-1:0] len;
        if (high_phase) begin
            len = hold ? W'(adc_ctrl_pkg::SH_HIGH_CYC)
                       : W'(adc_ctrl_pkg::FAST_HIGH_CYC); // R5 R6
        end else if (hold && (settle > W'(adc_ctrl_pkg::FAST_LOW_CYC))) begin
            len = settle; // R6
        end else begin
            // The low phase never drops below what makes the cycle 2.0 us.
            len = W'(adc_ctrl_pkg::FAST_LOW_CYC); // R3 R5
        end
        return len;
    endfunction : phase_cycles

    // The mode and settle time are taken once per conversion, at the
    // rising edge, so a change in mid-conversion waits for the next one.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_mode   <= 1'b0;
            hold_settle <= W'(adc_ctrl_pkg::FAST_LOW_CYC);
        end else if (enter_high) begin
            hold_mode   <= sh_mode;
            hold_settle <= sh_low_cycles;
        end
    end

    assign high_len = phase_cycles(1'b1, sh_mode, sh_low_cycles); // R5 R6
    assign low_len  = phase_cycles(1'b0, hold_mode, hold_settle); // R3 R4

    // Second guard on the 2.0 us cycle, counted from each rising edge.
    // The phase lengths already keep it; this stops a future change to
    // the constants from quietly breaking the rate limit.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            since_rise <= '1;
        end else if (enter_high) begin
            since_rise <= '0;
        end else if (since_rise != '1) begin
            since_rise <= since_rise + W'(1);
        end
    end

    assign rate_ok = since_rise >= W'(adc_ctrl_pkg::MIN_CYCLE_CYC - 1); // R3

    // A single request and the run level share one path into a cycle, so
    // continuous mode is nothing more than a request that stays up.
    assign go = start_req || run; // R4

    always_comb begin
        next_state = state;
        case (state)
            adc_ctrl_pkg::ST_IDLE: begin
                // A request is only taken once the cycle guard allows a rise.
                if (go && rate_ok) begin
                    next_state = adc_ctrl_pkg::ST_HIGH;
                end
            end
            adc_ctrl_pkg::ST_HIGH: begin
                if (timer_done) begin
                    next_state = adc_ctrl_pkg::ST_LOW;
                end
            end
            adc_ctrl_pkg::ST_LOW: begin
                // The low phase must end before a new rising edge, so
                // back-to-back conversions never beat the 2.0 us cycle.
                if (timer_done && !go) begin
                    next_state = adc_ctrl_pkg::ST_IDLE;
                end else if (timer_done && rate_ok) begin
                    next_state = adc_ctrl_pkg::ST_HIGH;
                end
            end
            default: begin
                next_state = adc_ctrl_pkg::ST_IDLE;
            end
        endcase
    end

    assign enter_high = (next_state == adc_ctrl_pkg::ST_HIGH)
                     && (state != adc_ctrl_pkg::ST_HIGH);
    assign enter_low  = (next_state == adc_ctrl_pkg::ST_LOW)
                     && (state != adc_ctrl_pkg::ST_LOW);
    assign timer_load = enter_high || enter_low; // R11
    // The timer loads N-1 so that each phase lasts exactly N cycles.
    assign timer_value = enter_high ? high_len - W'(1) : low_len - W'(1);

    // One timer serves both phases; it is reloaded at each phase entry and
    // rests at zero while the controller is idle.
    phase_timer #(
        .W (W)
    ) u_phase_timer (
        .sys_clk    (sys_clk),
        .rst_n      (rst_n),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    assign capture_now = capture_pending && (capture_count == '0);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= adc_ctrl_pkg::ST_IDLE;
            adc_start <= 1'b0;
        end else begin
            state     <= next_state;
            adc_start <= (next_state == adc_ctrl_pkg::ST_HIGH); // R1 R5 R6
        end
    end

    // Capture waits CAPTURE_CYC edges after the falling edge plus one more,
    // so data is read 150 ns after the fall: well past the 50 ns valid
    // time, and clear of a converter that answers right on a clock edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_pending <= 1'b0;
            capture_count   <= '0;
        end else if (enter_low) begin
            capture_pending <= 1'b1; // R10 R11
            capture_count   <= W'(adc_ctrl_pkg::CAPTURE_CYC);
        end else if (capture_now) begin
            capture_pending <= 1'b0;
        end else if (capture_pending) begin
            capture_count   <= capture_count - W'(1); // R2
        end
    end

    // Bit 1 on the device is the MSB, so adc_data[DATA_BITS-1] holds it.
    // sample_valid drops at every rise so a reader never takes a void word.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_valid     <= 1'b0;
            held             <= '0;
        end else if (enter_high) begin
            sample_valid     <= 1'b0; // R1
        end else if (capture_now) begin
            sample_valid     <= 1'b1;
            held             <= fresh; // R7 R8 R9
        end
    end

    // busy covers the capture wait too, so a caller that waits for it to
    // fall always finds the new result already in place.
    assign busy = (state != adc_ctrl_pkg::ST_IDLE) || capture_pending;

    // Word and overrange travel as one unit, overrange as the top bit.
    assign fresh = '{
        overrange: adc_overrange,
        code:      PW'(adc_data)
    }; // R8
    assign sample_overrange = held.overrange; // R8

    // Port index DATA_BITS-k carries device bit k, bit 1 being the MSB.
    for (genvar b = 0; b < DATA_BITS; b++) begin : g_code_bit
        assign sample_code[b] = held.code[b]; // R7
    end
endmodule : adc_start_ctrl
`default_nettype wire

//--- verilog/adc_ctrl_pkg.sv
// Purpose: Shared constants and types for the converter start controller.
// Assumes: System clock of 20 MHz, one period is 50 ns.
// Notes:   Times are kept in ns and turned into cycle counts here.
package adc_ctrl_pkg;

    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned DATA_BITS     = 14;

    // All times round up to whole cycles; capture is the valid time rounded down plus one.
    localparam int unsigned MIN_CYCLE_NS   = 2000;
    localparam int unsigned FAST_HIGH_NS   = 1800;
    localparam int unsigned FAST_LOW_NS    = 200;
    localparam int unsigned SH_HIGH_NS     = 2000;
    localparam int unsigned DATA_VALID_NS  = 50;

    localparam int unsigned MIN_CYCLE_CYC  =
        (MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAST_HIGH_CYC  =
        (FAST_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAST_LOW_CYC   =
        (FAST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SH_HIGH_CYC    =
        (SH_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Capture strictly more than the valid time after the falling edge.
    localparam int unsigned CAPTURE_CYC    = DATA_VALID_NS / CLK_PERIOD_NS + 1;

    localparam int unsigned CNT_W          = 16;
    localparam logic [15:0] SH_LOW_RESET   = 16'h000a;

    typedef struct packed {
        logic                 overrange;
        logic [DATA_BITS-1:0] code;
    } sample_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_HIGH   = 2'b01,
        ST_LOW    = 2'b10
    } phase_e;

endpackage : adc_ctrl_pkg

//--- verilog/phase_timer.sv
// Purpose: Loadable down counter that marks when a phase has run out.
// Assumes: Load and the count share the system clock.
// Notes:   done is high while the count is zero.
`timescale 1ns/1ns
`default_nettype none
module phase_timer #(
    parameter int unsigned W = 16
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              done
);
    logic [W-1:0] count;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (load) begin
            count <= load_value;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign done = (count == '0);
endmodule : phase_timer
`default_nettype wire

//--- sim/adc_model.sv
// Purpose: Converter model, coarse pass at strobe rise, fine pass at fall.
// Assumes: level is the ideal result, overrange in bit 14.
// Notes:   Old data is inverted at the rise so stale values never match.
`timescale 1ns/1ns
`default_nettype none
module adc_model #(
    parameter int VALID_NS = 50
) (
    input  wire logic        adc_start,
    input  wire logic [14:0] level,
    output logic [13:0]      adc_data,
    output logic             adc_overrange
);
    logic [14:0] coarse = 15'h0000;
    initial {adc_overrange, adc_data} = 15'h0000;
    always @(posedge adc_start) begin
        coarse = {level[14:7], 7'h00};
        {adc_overrange, adc_data} = ~{adc_overrange, adc_data};
    end
    // Answers at the latest legal moment to stress the capture delay.
    always @(negedge adc_start) begin
        #(VALID_NS) {adc_overrange, adc_data} = coarse + (level - coarse);
    end
endmodule : adc_model
`default_nettype wire

//--- sim/adc_start_ctrl_asserts.sv
// Purpose: Strobe timing and capture checks.
// Assumes: sh_mode is steady through each conversion.
// Notes:   The low counter saturates so reset counts as a long idle.
`timescale 1ns/1ns
`default_nettype none
module adc_start_ctrl_asserts #(
    parameter int unsigned DATA_BITS = 14
) (
    input wire logic                 sys_clk,
    input wire logic                 rst_n,
    input wire logic                 start_req,
    input wire logic                 run,
    input wire logic                 sh_mode,
    input wire logic [15:0]          sh_low_cycles,
    input wire logic [DATA_BITS-1:0] adc_data,
    input wire logic                 adc_overrange,
    input wire logic                 adc_start,
    input wire logic                 busy,
    input wire logic                 sample_valid,
    input wire logic [DATA_BITS-1:0] sample_code,
    input wire logic                 sample_overrange
);
    logic [15:0] hi_cnt;
    logic [15:0] lo_cnt;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) {hi_cnt, lo_cnt} <= 32'h0000ffff;
        else {hi_cnt, lo_cnt} <= adc_start ? {hi_cnt + 16'h0001, 16'h0000}
            : {16'h0000, lo_cnt + {15'h0000, ~&lo_cnt}};
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_rise_voids: assert property ($rose(adc_start) |-> !sample_valid)
        else $error("old result still valid at strobe rise");
    a_start_answer: assert property (start_req && !busy && !adc_start
        |=> $rose(adc_start)) else $error("strobe late after request");
    a_busy_strobe: assert property (adc_start |-> busy)
        else $error("busy low while strobe high");
    a_high_len: assert property ($fell(adc_start) |->
        hi_cnt == (sh_mode ? 16'h0028 : 16'h0024)) else $error("high length");
    a_low_min: assert property ($rose(adc_start) |-> lo_cnt >= 16'h0004 &&
        (!sh_mode || lo_cnt >= sh_low_cycles)) else $error("low too short");
    a_capture_delay: assert property ($fell(adc_start) && !run &&
        !start_req |-> !sample_valid[*3] ##1 sample_valid)
        else $error("capture not three edges after fall");
    a_data_latch: assert property ($rose(sample_valid) |->
        {sample_overrange, sample_code} == $past({adc_overrange, adc_data}))
        else $error("captured word differs from converter");
    a_data_hold: assert property (sample_valid && $past(sample_valid) |->
        $stable({sample_overrange, sample_code})) else $error("result moved");
    c_fast: cover property ($fell(adc_start) && !sh_mode);
    c_hold: cover property ($fell(adc_start) && sh_mode);
    c_over: cover property ($rose(sample_valid) && sample_overrange);
endmodule : adc_start_ctrl_asserts
bind adc_start_ctrl adc_start_ctrl_asserts #(.DATA_BITS(DATA_BITS)) chk_u (.*);
`default_nettype wire

//--- sim/adc_start_ctrl_bench.sv
// Purpose: Self-checking bench for the converter start controller.
// Assumes: Inputs change on the falling clock edge.
// Notes:   The model returns the level that each scenario sets.
`timescale 1ns/1ns
`default_nettype none
module adc_start_ctrl_bench;
    logic sys_clk = 1'b0, rst_n = 1'b0, start_req = 1'b0, run = 1'b0;
    logic sh_mode = 1'b0, adc_overrange, adc_start, busy;
    logic sample_valid, sample_overrange;
    logic [15:0] sh_low_cycles = 16'h000a;
    logic [14:0] level = 15'h0000;
    logic [13:0] adc_data, sample_code;
    int error_cnt = 0, checks = 0;
    always #25 sys_clk = ~sys_clk;
    adc_start_ctrl dut_u (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .start_req        (start_req),
        .run              (run),
        .sh_mode          (sh_mode),
        .sh_low_cycles    (sh_low_cycles),
        .adc_data         (adc_data),
        .adc_overrange    (adc_overrange),
        .adc_start        (adc_start),
        .busy             (busy),
        .sample_valid     (sample_valid),
        .sample_code      (sample_code),
        .sample_overrange (sample_overrange)
    );
    adc_model model_u (
        .adc_start     (adc_start),
        .level         (level),
        .adc_data      (adc_data),
        .adc_overrange (adc_overrange)
    );
    task automatic chk(input string what, input logic [15:0] exp, got);
        checks++;
        if (exp !== got) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_valid(input logic [14:0] lvl);
        for (int n = 0; n < 200 && sample_valid !== 1'b1; n++) @(negedge sys_clk);
        chk("valid", 16'h0001, {15'h0000, sample_valid});
        chk("result", {1'b0, lvl}, {1'b0, sample_overrange, sample_code});
    endtask : wait_valid
    task automatic single(input logic [14:0] lvl);
        level = lvl;
        start_req = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("busy", 16'h0001, {15'h0000, busy});
        chk("voided", 16'h0000, {15'h0000, sample_valid});
        start_req = 1'b0;
        wait_valid(lvl);
    endtask : single
    task automatic burst(input logic sh, input logic [15:0] low, per,
                         input logic [14:0] lvl);
        realtime t;
        sh_mode = sh;
        sh_low_cycles = low;
        level = lvl;
        run = 1'b1;
        @(posedge adc_start);
        t = $realtime;
        @(posedge adc_start);
        chk("period", per, 16'(int'(($realtime - t) / 50.0)));
        @(negedge sys_clk);
        run = 1'b0;
        wait_valid(lvl);
        // Let the line idle so the next burst starts from a long low phase.
        repeat (16) @(negedge sys_clk);
    endtask : burst
    task automatic final_report();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        single(15'h0000);
        single(15'h3fff);
        single(15'h4000);
        single(15'h40bf);
        burst(1'b0, 16'h000a, 16'h0028, 15'h2001);
        burst(1'b1, 16'h000a, 16'h0032, 15'h1234);
        burst(1'b1, 16'h0002, 16'h002c, 15'h0001);
        final_report();
    end
    // Whole run needs under 1000 cycles; five times that means a hang.
    initial begin
        #250000;
        error_cnt++;
        final_report();
    end
endmodule : adc_start_ctrl_bench
`default_nettype wire
